// ===== common/bnv_defines.svh
// timing and width constants for the bytewide nonvolatile memory host port
`ifndef BNV_DEFINES_SVH
`define BNV_DEFINES_SVH
`define BNV_ADDR_W        15
`define BNV_DATA_W        8
`define BNV_CLK_NS        100
`define BNV_ACCESS_NS     70
`define BNV_PRECHARGE_NS  60
`define BNV_ADDR_HOLD_NS  20
`define BNV_CE_LOW_MAX_NS 10000
`define BNV_CDIV(ns)      (((ns) + `BNV_CLK_NS - 1) / `BNV_CLK_NS)
`define BNV_FDIV(ns)      ((ns) / `BNV_CLK_NS)
`define BNV_ACCESS_CYC    `BNV_CDIV(`BNV_ACCESS_NS)
`define BNV_PRECHARGE_CYC `BNV_CDIV(`BNV_PRECHARGE_NS)
`define BNV_HOLD_CYC      `BNV_CDIV(`BNV_ADDR_HOLD_NS)
`define BNV_CE_MAX_CYC    `BNV_FDIV(`BNV_CE_LOW_MAX_NS)
`define BNV_CNT_W         8
`endif

// ===== common/bnv_pkg.sv
// types for the bytewide nonvolatile memory host port
package bnv_pkg;
  `include "bnv_defines.svh"
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_HOLD,
    ST_PRECHARGE
  } bnv_state_type;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`BNV_ADDR_W-1:0]  addr;
    logic [`BNV_DATA_W-1:0]  wdata;
  } bnv_req_type;

  typedef struct packed {
    logic                    valid;
    logic [`BNV_DATA_W-1:0]  rdata;
  } bnv_rsp_type;

  typedef struct packed {
    logic                    select_strobe_n;
    logic                    write_strobe_n;
    logic                    output_drive_n;
    logic [`BNV_ADDR_W-1:0]  addr_lines;
    logic [`BNV_DATA_W-1:0]  data_lines_out;
    logic                    data_lines_oe;
  } bnv_pins_type;
endpackage

// ===== hdl/bnv_sync3.sv
// three-stage synchroniser for the data_lines inputs
`timescale 1ns/1ps
`include "bnv_defines.svh"
module bnv_sync3 (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`BNV_DATA_W-1:0] din,
  output logic      [`BNV_DATA_W-1:0] dout
);
  import bnv_pkg::*;
  typedef struct packed {
    logic [`BNV_DATA_W-1:0] s1;
    logic [`BNV_DATA_W-1:0] s2;
    logic [`BNV_DATA_W-1:0] s3;
    logic [`BNV_DATA_W-1:0] stable;
  } bnv_sync_type;
  bnv_sync_type q, d;

  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // accept a value only once the last two stages agree
    if (q.s2 == q.s3) begin
      d.stable = q.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;
endmodule

// ===== hdl/bnv_host.sv
// host controller driving a bytewide nonvolatile memory over its strobe pins
`timescale 1ns/1ps
`include "bnv_defines.svh"
module bnv_host (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire bnv_pkg::bnv_req_type   req,
  output logic                        req_ready,
  output bnv_pkg::bnv_rsp_type        rsp,
  output logic                        select_strobe_n,
  output logic                        write_strobe_n,
  output logic                        output_drive_n,
  output logic [`BNV_ADDR_W-1:0]      addr_lines,
  output logic [`BNV_DATA_W-1:0]      data_lines_out,
  output logic                        data_lines_oe,
  input  wire logic [`BNV_DATA_W-1:0] data_lines_in
);
  import bnv_pkg::*;

  typedef struct packed {
    bnv_state_type           state;
    logic [`BNV_CNT_W-1:0]   cnt;
    logic                    write;
    bnv_pins_type            pins;
    bnv_rsp_type             rsp;
  } bnv_host_state_type;

  bnv_host_state_type q, d;
  logic [`BNV_DATA_W-1:0] rd_sync;

  function automatic logic [`BNV_CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `BNV_CNT_W'(1) : `BNV_CNT_W'(n);
  endfunction

  bnv_sync3 u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (data_lines_in),
    .dout  (rd_sync)
  );

  // idle pins: all strobes high, bus released
  localparam bnv_pins_type PINS_IDLE = '{select_strobe_n: 1'b1, write_strobe_n: 1'b1,
                                         output_drive_n: 1'b1, addr_lines: '0,
                                         data_lines_out: '0, data_lines_oe: 1'b0};

  always_comb begin
    d = q;
    d.rsp.valid = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (req.valid) begin
          // address and write data set up one cycle before select falls
          d.pins.addr_lines = req.addr;
          d.write = req.write;
          d.pins.data_lines_out = req.wdata;
          // write strobe goes low before select: select-controlled write
          d.pins.write_strobe_n = !req.write;
          d.pins.data_lines_oe = req.write;
          d.pins.output_drive_n = 1'b1;
          d.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // each access opens with a fresh select fall, latching the address
        d.pins.select_strobe_n = 1'b0;
        d.pins.output_drive_n = q.write;
        d.cnt = cyc(`BNV_ACCESS_CYC);
        d.state = ST_ACCESS;
      end
      ST_ACCESS: begin
        // same access time for both directions; bounded select low time
        if (q.cnt > `BNV_CNT_W'(1)) begin
          d.cnt = q.cnt - `BNV_CNT_W'(1);
        end else begin
          d.cnt = cyc(`BNV_HOLD_CYC);
          d.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // read data sampled after sync latency; rising select ends write
        d.pins.select_strobe_n = 1'b1;
        d.pins.write_strobe_n = 1'b1;
        d.pins.output_drive_n = 1'b1;
        // write data stays driven one more cycle: no hold race at the strobe rise
        d.cnt = cyc(`BNV_PRECHARGE_CYC + 2);
        d.state = ST_PRECHARGE;
      end
      ST_PRECHARGE: begin
        // select held high for pre-charge; covers sync latency of read data
        d.pins.data_lines_oe = 1'b0;
        if (q.cnt > `BNV_CNT_W'(1)) begin
          d.cnt = q.cnt - `BNV_CNT_W'(1);
        end else begin
          d.rsp.valid = 1'b1;
          d.rsp.rdata = q.write ? q.pins.data_lines_out : rd_sync;
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
        d.pins = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{state: ST_IDLE, cnt: '0, write: 1'b0, pins: PINS_IDLE, rsp: '0};
    end else begin
      q <= d;
    end
  end

  // address stays put through the whole cycle, well past hold time
  assign req_ready       = (q.state == ST_IDLE);
  assign rsp             = q.rsp;
  assign select_strobe_n = q.pins.select_strobe_n;
  assign write_strobe_n  = q.pins.write_strobe_n;
  assign output_drive_n  = q.pins.output_drive_n;
  assign addr_lines      = q.pins.addr_lines;
  assign data_lines_out  = q.pins.data_lines_out;
  assign data_lines_oe   = q.pins.data_lines_oe;
endmodule

// ===== sim/bnv_host_props.sv
// assertion checker for the nonvolatile memory host port
`timescale 1ns/1ps
`include "bnv_defines.svh"
module bnv_host_props (
  input logic                   clk,
  input logic                   rst_n,
  input bnv_pkg::bnv_req_type   req,
  input logic                   req_ready,
  input bnv_pkg::bnv_rsp_type   rsp,
  input logic                   select_strobe_n,
  input logic                   write_strobe_n,
  input logic                   output_drive_n,
  input logic [`BNV_ADDR_W-1:0] addr_lines,
  input logic [`BNV_DATA_W-1:0] data_lines_out,
  input logic                   data_lines_oe,
  input logic [`BNV_DATA_W-1:0] data_lines_in
);
  import bnv_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; req.valid && req_ready; endsequence
  sequence s_cycle; !select_strobe_n [*2] ##1 select_strobe_n [*2]; endsequence
  AST_ANSWER: assert property (s_take |-> ##7 rsp.valid) else $error("late answer");
  AST_START: assert property (s_take |-> ##2 $fell(select_strobe_n)) else $error("no strobe fall");
  AST_CYCLE: assert property ($fell(select_strobe_n) |-> s_cycle) else $error("bad access");
  AST_WSET: assert property ($fell(select_strobe_n) |-> $stable(write_strobe_n)) else $error("we moved");
  AST_WEND: assert property (!write_strobe_n && !select_strobe_n |=> !write_strobe_n || select_strobe_n)
    else $error("we early");
  AST_WDATA: assert property (!write_strobe_n && !select_strobe_n |-> data_lines_oe && $stable(data_lines_out))
    else $error("data moved");
  AST_ADDR: assert property (!select_strobe_n |-> $stable(addr_lines)) else $error("addr moved");
  AST_BUS: assert property (!output_drive_n |-> !data_lines_oe && write_strobe_n) else $error("bus clash");
  AST_AOUT: assert property (s_take |=> addr_lines == $past(req.addr)) else $error("wrong addr");
  AST_WHOLD: assert property ($rose(select_strobe_n) && !$past(write_strobe_n) |->
    data_lines_oe && $stable(data_lines_out)) else $error("data released early");
endmodule
bind bnv_host bnv_host_props u_props (.clk, .rst_n, .req, .req_ready, .rsp, .select_strobe_n, .write_strobe_n,
  .output_drive_n, .addr_lines, .data_lines_out, .data_lines_oe, .data_lines_in);

// ===== sim/bnv_mem_model.sv
// behavioural model of the bytewide nonvolatile memory
`timescale 1ns/1ps
`include "bnv_defines.svh"
module bnv_mem_model (
  input  logic                   select_strobe_n,
  input  logic                   write_strobe_n,
  input  logic                   output_drive_n,
  input  logic [`BNV_ADDR_W-1:0] addr_lines,
  input  logic [`BNV_DATA_W-1:0] data_in,
  output logic [`BNV_DATA_W-1:0] data_out
);
  logic [`BNV_DATA_W-1:0] mem [2**`BNV_ADDR_W];
  logic [`BNV_ADDR_W-1:0] lat;
  logic                   wr, act, rdy;
  logic [`BNV_DATA_W-1:0] q;
  initial {wr, act, rdy, q} = '0;
  always @(negedge select_strobe_n) begin
    lat = addr_lines;
    wr = !write_strobe_n;
    act = 1'b1;
    rdy = 1'b0;
    #(`BNV_ACCESS_NS) rdy = 1'b1;
  end
  always @(negedge write_strobe_n) if (!select_strobe_n) wr = 1'b1;
  always @(posedge select_strobe_n or posedge write_strobe_n) if (act && wr) begin
    mem[lat] = data_in;
    act = 1'b0;
  end
  always @(negedge output_drive_n or posedge rdy) if (!output_drive_n && rdy && !wr) q = mem[lat];
  // undriven bus shows the inverse of the last byte, so a late sample cannot pass
  assign data_out = (!output_drive_n && rdy && !wr) ? q : ~q;
endmodule

// ===== sim/tb.sv
// self-checking bench for the nonvolatile memory host port
`timescale 1ns/1ps
`include "bnv_defines.svh"
module tb;
  import bnv_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  bnv_req_type            req = '0;
  bnv_rsp_type            rsp;
  logic                   req_ready, select_strobe_n, write_strobe_n, output_drive_n, data_lines_oe;
  logic [`BNV_ADDR_W-1:0] addr_lines;
  logic [`BNV_DATA_W-1:0] data_lines_out, data_lines_in, pin;
  int                     err_count = 0;
  int                     samples_checked = 0;
  always #50 clk = ~clk;
  // released host pins show the inverse so a stale byte cannot pass
  assign pin = data_lines_oe ? data_lines_out : ~data_lines_out;
  bnv_host DUT (.clk, .rst_n, .req, .req_ready, .rsp, .select_strobe_n, .write_strobe_n, .output_drive_n,
    .addr_lines, .data_lines_out, .data_lines_oe, .data_lines_in);
  bnv_mem_model u_mem (.select_strobe_n, .write_strobe_n, .output_drive_n, .addr_lines, .data_in(pin),
    .data_out(data_lines_in));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(int n);
    if (n >= 50) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic access(logic w, logic [14:0] a, logic [7:0] d, logic [7:0] exp);
    int n;
    @(posedge clk) req <= '{1'b1, w, a, d};
    n = 0;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
    bound(n);
    @(posedge clk) req.valid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (rsp.valid !== 1'b1 && n < 50);
    bound(n);
    // answer registered six edges after the take, seen at the seventh negedge
    check(n, 7);
    check(rsp.rdata, exp);
  endtask
  task automatic t_idle();
    check({select_strobe_n, write_strobe_n, output_drive_n, data_lines_oe, req_ready}, 5'h1d);
    $display("idle test done");
  endtask
  task automatic t_bounds();
    access(1, 15'h0000, 8'ha5, 8'ha5);
    access(1, 15'h7fff, 8'h5a, 8'h5a);
    access(0, 15'h0000, 8'h00, 8'ha5);
    access(0, 15'h7fff, 8'h00, 8'h5a);
    $display("bounds test done");
  endtask
  task automatic t_b2b();
    for (int i = 0; i < 4; i++) begin
      access(1, 15'h0100 << i, 8'h3c ^ i[7:0], 8'h3c ^ i[7:0]);
      access(0, 15'h0100 << i, 8'h00, 8'h3c ^ i[7:0]);
    end
    $display("back to back test done");
  endtask
  task automatic t_midreset();
    @(posedge clk) req <= '{1'b1, 1'b1, 15'h0002, 8'hee};
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    req <= '0;
    @(posedge clk) rst_n <= 1'b1;
    @(negedge clk);
    t_idle();
    access(0, 15'h7fff, 8'h00, 8'h5a);
    $display("mid reset test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_idle();
    t_bounds();
    t_b2b();
    t_midreset();
    stop_test();
  end
endmodule
